// *** core/tid_core.sv ***
// Purpose: Fetch, decode and execute the data-transfer instruction group
// Assumes: Single byte memory port; writes complete on the strobe cycle
// Notes: One memory access is outstanding at a time; unknown codes act as no-ops
`timescale 1ns/1ps
`default_nettype none

// Notes on behaviour
// - Accumulator is 16 bits, used as 8 or 16, with separate high and low bytes.
// - Temporary accumulator likewise byte or word, high and low bytes separately usable.
// - Index, extra pointer, program counter and stack pointer are 16-bit registers.
// - Status word is 16 bits: 8-bit flag register plus 5-bit bank pointer.
// - Each bank holds eight byte general registers numbered zero to seven.
// - Operands: page-zero, offset, branch 8 bits; address 16; vector 3; bit 8:3.
// - Word store puts acc high at address, acc low at address plus one.
// - Byte load copies old acc low to temp low only; sets N and Z.
// - Word load: high from address, low from next; old acc to temp; N, Z.
// - Range opcodes fill every code; low three bits pick register or bit.
// - Operand bytes follow the opcode in assembler operand order.
// - Pointer word store writes temp high at acc address, temp low next.
// - Only the flags marked for an instruction change; all others hold.
// - Acc high gets upper result byte where written; unmarked registers hold.
// - Values copied to temp are those held before the instruction began.
module tid_core
	import tid_pkg::*;
(
	input wire logic clk_i,
	input wire logic arst_n_i,
	input wire logic [7:0] mem_rdata_i,
	input wire logic mem_rvalid_i,
	output tid_mem_type mem_o,
	output tid_arch_type arch_o,
	output logic instr_done_o,
	output logic illegal_o
);

	typedef struct packed {
		tid_state_type st;
		tid_arch_type arch;
		logic [7:0] op;
		logic [7:0] opnd1;
		logic [7:0] opnd2;
		logic [15:0] ea;
		logic [15:0] data;
		logic [1:0] cnt;
		logic pend;
		tid_mem_type mem;
		logic done;
		logic bad;
	} tid_core_type;

	tid_core_type q, d;
	tid_dec_type dec;
	logic [7:0] key;
	logic [15:0] ea;
	logic [7:0] wbyte;
	logic [7:0] bitmask;

	always_comb begin
		key = q.op;
		if (q.op[7:3] == OP_ST_REG[7:3] || q.op[7:3] == OP_LD_REG[7:3] || q.op[7:3] == OP_SI_REG[7:3]
			|| q.op[7:3] == OP_BSET[7:3] || q.op[7:3] == OP_BCLR[7:3]) begin
			key = {q.op[7:3], 3'b000};
		end
	end

	always_comb begin
		case (key)
			OP_ST_DIR: dec = '{LEN2, AM_DIR, K_STA, CNT0, CNT1};
			OP_ST_IX: dec = '{LEN2, AM_IX, K_STA, CNT0, CNT1};
			OP_ST_EXT: dec = '{LEN3, AM_EXT, K_STA, CNT0, CNT1};
			OP_ST_EP: dec = '{LEN1, AM_EP, K_STA, CNT0, CNT1};
			OP_ST_REG: dec = '{LEN1, AM_REG, K_STA, CNT0, CNT1};
			OP_LD_IMM: dec = '{LEN2, AM_NONE, K_LDB, CNT0, CNT0};
			OP_LD_DIR: dec = '{LEN2, AM_DIR, K_LDB, CNT1, CNT0};
			OP_LD_IX: dec = '{LEN2, AM_IX, K_LDB, CNT1, CNT0};
			OP_LD_EXT: dec = '{LEN3, AM_EXT, K_LDB, CNT1, CNT0};
			OP_LD_ACC: dec = '{LEN1, AM_ACC, K_LDB, CNT1, CNT0};
			OP_LD_EP: dec = '{LEN1, AM_EP, K_LDB, CNT1, CNT0};
			OP_LD_REG: dec = '{LEN1, AM_REG, K_LDB, CNT1, CNT0};
			OP_SI_DIR: dec = '{LEN3, AM_DIR, K_STI, CNT0, CNT1};
			OP_SI_IX: dec = '{LEN3, AM_IX, K_STI, CNT0, CNT1};
			OP_SI_EP: dec = '{LEN2, AM_EP, K_STI, CNT0, CNT1};
			OP_SI_REG: dec = '{LEN2, AM_REG, K_STI, CNT0, CNT1};
			OP_ST_TMP: dec = '{LEN1, AM_ACC, K_STT, CNT0, CNT1};
			OP_SW_DIR: dec = '{LEN2, AM_DIR, K_STW, CNT0, CNT2};
			OP_SW_IX: dec = '{LEN2, AM_IX, K_STW, CNT0, CNT2};
			OP_SW_EXT: dec = '{LEN3, AM_EXT, K_STW, CNT0, CNT2};
			OP_SW_EP: dec = '{LEN1, AM_EP, K_STW, CNT0, CNT2};
			OP_LW_IMM: dec = '{LEN3, AM_NONE, K_LDW, CNT0, CNT0};
			OP_LW_DIR: dec = '{LEN2, AM_DIR, K_LDW, CNT2, CNT0};
			OP_LW_IX: dec = '{LEN2, AM_IX, K_LDW, CNT2, CNT0};
			OP_LW_EXT: dec = '{LEN3, AM_EXT, K_LDW, CNT2, CNT0};
			OP_LW_ACC: dec = '{LEN1, AM_ACC, K_LDW, CNT2, CNT0};
			OP_LW_EP: dec = '{LEN1, AM_EP, K_LDW, CNT2, CNT0};
			OP_SW_TMP: dec = '{LEN1, AM_ACC, K_STTW, CNT0, CNT2};
			OP_BSET: dec = '{LEN2, AM_DIR, K_BSET, CNT1, CNT1};
			OP_BCLR: dec = '{LEN2, AM_DIR, K_BCLR, CNT1, CNT1};
			OP_NOP, OP_SWAP, OP_TRADE_LO, OP_TRADE_T, OP_A_PSW, OP_PSW_A, OP_SP_A, OP_IX_A, OP_EP_A,
			OP_A_PC, OP_A_SP, OP_A_IX, OP_A_EP, OP_TRADE_SP, OP_TRADE_IX, OP_TRADE_EP:
				dec = '{LEN1, AM_NONE, K_REG, CNT0, CNT0};
			OP_SP_IMM, OP_IX_IMM, OP_EP_IMM: dec = '{LEN3, AM_NONE, K_REG, CNT0, CNT0};
			default: dec = '{LEN1, AM_NONE, K_BAD, CNT0, CNT0};
		endcase
	end

	tid_addr_gen u_addr_gen (
		.amode_i(dec.amode),
		.opnd1_i(q.opnd1),
		.opnd2_i(q.opnd2),
		.regno_i(q.op[2:0]),
		.bank_i(q.arch.bank),
		.ix_i(q.arch.ix),
		.ep_i(q.arch.ep),
		.acc_i(q.arch.acc),
		.ea_o(ea)
	);

	// Outgoing byte for each write slot
	always_comb begin
		bitmask = 8'h01 << q.op[2:0];
		case (dec.kind)
			K_STW: wbyte = (q.cnt == CNT0) ? q.arch.acc[15:8] : q.arch.acc[7:0];
			K_STTW: wbyte = (q.cnt == CNT0) ? q.arch.tmp[15:8] : q.arch.tmp[7:0];
			K_STT: wbyte = q.arch.tmp[7:0];
			K_STI: wbyte = (dec.len == LEN3) ? q.opnd2 : q.opnd1;
			K_BSET: wbyte = q.data[7:0] | bitmask;
			K_BCLR: wbyte = q.data[7:0] & ~bitmask;
			default: wbyte = q.arch.acc[7:0];
		endcase
	end

	// Sequencer and execution
	always_comb begin
		d = q;
		d.mem.rd = 1'b0;
		d.mem.wr = 1'b0;
		d.done = 1'b0;
		case (q.st)
			ST_FETCH: begin
				if (!q.pend) begin
					d.mem.rd = 1'b1;
					d.mem.addr = q.arch.pc;
					d.pend = 1'b1;
				end else if (mem_rvalid_i) begin
					d.op = mem_rdata_i;
					d.pend = 1'b0;
					d.arch.pc = q.arch.pc + 16'h0001;
					d.cnt = CNT0;
					d.st = ST_OPND;
				end
			end
			ST_OPND: begin
				if (q.cnt == dec.len - LEN1) begin
					d.st = ST_ADDR;
				end else if (!q.pend) begin
					d.mem.rd = 1'b1;
					d.mem.addr = q.arch.pc;
					d.pend = 1'b1;
				end else if (mem_rvalid_i) begin
					// first operand byte follows the opcode
					if (q.cnt == CNT0) begin
						d.opnd1 = mem_rdata_i;
					end else begin
						d.opnd2 = mem_rdata_i;
					end
					d.pend = 1'b0;
					d.arch.pc = q.arch.pc + 16'h0001;
					d.cnt = q.cnt + CNT1;
				end
			end
			ST_ADDR: begin
				d.ea = ea;
				d.data = (dec.len == LEN3) ? {q.opnd1, q.opnd2} : {8'h00, q.opnd1};
				d.cnt = CNT0;
				if (dec.nrd != CNT0) begin
					d.st = ST_READ;
				end else if (dec.nwr != CNT0) begin
					d.st = ST_WRITE;
				end else begin
					d.st = ST_EXEC;
				end
			end
			ST_READ: begin
				if (!q.pend) begin
					d.mem.rd = 1'b1;
					d.mem.addr = q.ea + {14'h0000, q.cnt};
					d.pend = 1'b1;
				end else if (mem_rvalid_i) begin
					if (dec.nrd == CNT2 && q.cnt == CNT0) begin
						d.data[15:8] = mem_rdata_i;
					end else begin
						d.data[7:0] = mem_rdata_i;
					end
					d.pend = 1'b0;
					d.cnt = q.cnt + CNT1;
					if (q.cnt + CNT1 == dec.nrd) begin
						d.cnt = CNT0;
						d.st = (dec.nwr != CNT0) ? ST_WRITE : ST_EXEC;
					end
				end
			end
			ST_WRITE: begin
				d.mem.wr = 1'b1;
				d.mem.addr = q.ea + {14'h0000, q.cnt};
				d.mem.wdata = wbyte;
				d.cnt = q.cnt + CNT1;
				if (q.cnt + CNT1 == dec.nwr) begin
					d.st = ST_EXEC;
				end
			end
			ST_EXEC: begin
				d.done = 1'b1;
				d.bad = (dec.kind == K_BAD);
				d.st = ST_FETCH;
				case (dec.kind)
					// byte load, old low byte to temp
					K_LDB: begin
						d.arch.tmp[7:0] = q.arch.acc[7:0];
						d.arch.acc[7:0] = q.data[7:0];
						d.arch.flag_register[FLAG_N] = q.data[7];
						d.arch.flag_register[FLAG_Z] = (q.data[7:0] == 8'h00);
					end
					K_LDW: begin
						// acc high takes upper result byte
						d.arch.tmp = q.arch.acc;
						d.arch.acc = q.data;
						d.arch.flag_register[FLAG_N] = q.data[15];
						d.arch.flag_register[FLAG_Z] = (q.data == 16'h0000);
					end
					K_REG: begin
						case (q.op)
							OP_SWAP: d.arch.acc = {q.arch.acc[7:0], q.arch.acc[15:8]};
							OP_TRADE_LO: begin
								d.arch.acc[7:0] = q.arch.tmp[7:0];
								d.arch.tmp[7:0] = q.arch.acc[7:0];
							end
							OP_TRADE_T: begin
								d.arch.acc = q.arch.tmp;
								d.arch.tmp = q.arch.acc;
							end
							OP_A_PSW: begin
								d.arch.acc = 16'h0000;
								d.arch.acc[PSW_BANK_LSB +: BANK_W] = q.arch.bank;
								d.arch.acc[BYTE_W-1:0] = q.arch.flag_register;
							end
							OP_PSW_A: begin
								d.arch.bank = q.arch.acc[PSW_BANK_LSB +: BANK_W];
								d.arch.flag_register = q.arch.acc[BYTE_W-1:0];
							end
							OP_SP_A: d.arch.sp = q.arch.acc;
							OP_IX_A: d.arch.ix = q.arch.acc;
							OP_EP_A: d.arch.ep = q.arch.acc;
							OP_A_PC: d.arch.acc = q.arch.pc;
							OP_A_SP: d.arch.acc = q.arch.sp;
							OP_A_IX: d.arch.acc = q.arch.ix;
							OP_A_EP: d.arch.acc = q.arch.ep;
							OP_TRADE_SP: begin
								d.arch.acc = q.arch.sp;
								d.arch.sp = q.arch.acc;
							end
							OP_TRADE_IX: begin
								d.arch.acc = q.arch.ix;
								d.arch.ix = q.arch.acc;
							end
							OP_TRADE_EP: begin
								d.arch.acc = q.arch.ep;
								d.arch.ep = q.arch.acc;
							end
							OP_SP_IMM: d.arch.sp = q.data;
							OP_IX_IMM: d.arch.ix = q.data;
							OP_EP_IMM: d.arch.ep = q.data;
							default: d.arch = q.arch;
						endcase
					end
					default: d.arch = q.arch;
				endcase
			end
			default: d.st = ST_FETCH;
		endcase
	end

	always_ff @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			q <= '0;
			q.st <= ST_FETCH;
			q.arch.pc <= RESET_PC;
			q.arch.sp <= RESET_WORD;
			q.arch.ix <= RESET_WORD;
			q.arch.ep <= RESET_WORD;
			q.arch.acc <= RESET_WORD;
			q.arch.tmp <= RESET_WORD;
			q.arch.flag_register <= RESET_CCR;
			q.arch.bank <= RESET_BANK;
		end else begin
			q <= d;
		end
	end

	// Outputs straight from the state register
	assign mem_o = q.mem;
	assign arch_o = q.arch;
	assign instr_done_o = q.done;
	assign illegal_o = q.bad;

endmodule : tid_core
`default_nettype wire

// *** core/tid_pkg.sv ***
// Purpose: Shared types and constants for the transfer instruction decoder
// Assumes: Byte-wide unified memory port, read data returns with a valid pulse
// Notes: Opcode names describe the operation; ranges are given by their base code
package tid_pkg;

	// Architectural widths
	localparam int unsigned BYTE_W = 8;
	localparam int unsigned WORD_W = 16;
	localparam int unsigned BANK_W = 5;
	localparam int unsigned REGNO_W = 3;

	// Reset values
	localparam logic [15:0] RESET_PC = 16'h0000;
	localparam logic [15:0] RESET_WORD = 16'h0000;
	localparam logic [7:0] RESET_CCR = 8'h00;
	localparam logic [4:0] RESET_BANK = 5'h00;

	// Data space layout: banks of general registers and page zero
	localparam logic [15:0] GREG_BASE = 16'h0100;
	localparam logic [7:0] PAGE_ZERO_HI = 8'h00;

	// Flag positions in the flag register, bank pointer position in the status word
	localparam int unsigned FLAG_N = 3;
	localparam int unsigned FLAG_Z = 2;
	localparam int unsigned FLAG_V = 1;
	localparam int unsigned FLAG_C = 0;
	localparam int unsigned PSW_BANK_LSB = 11;

	// Instruction lengths in bytes, and byte access counts
	localparam logic [1:0] LEN1 = 2'h1;
	localparam logic [1:0] LEN2 = 2'h2;
	localparam logic [1:0] LEN3 = 2'h3;
	localparam logic [1:0] CNT0 = 2'h0;
	localparam logic [1:0] CNT1 = 2'h1;
	localparam logic [1:0] CNT2 = 2'h2;

	// Byte moves
	localparam logic [7:0] OP_ST_DIR = 8'h45;
	localparam logic [7:0] OP_ST_IX = 8'h46;
	localparam logic [7:0] OP_ST_EXT = 8'h61;
	localparam logic [7:0] OP_ST_EP = 8'h47;
	localparam logic [7:0] OP_ST_REG = 8'h48;
	localparam logic [7:0] OP_LD_IMM = 8'h04;
	localparam logic [7:0] OP_LD_DIR = 8'h05;
	localparam logic [7:0] OP_LD_IX = 8'h06;
	localparam logic [7:0] OP_LD_EXT = 8'h60;
	localparam logic [7:0] OP_LD_ACC = 8'h92;
	localparam logic [7:0] OP_LD_EP = 8'h07;
	localparam logic [7:0] OP_LD_REG = 8'h08;
	localparam logic [7:0] OP_SI_DIR = 8'h85;
	localparam logic [7:0] OP_SI_IX = 8'h86;
	localparam logic [7:0] OP_SI_EP = 8'h87;
	localparam logic [7:0] OP_SI_REG = 8'h88;
	localparam logic [7:0] OP_ST_TMP = 8'h82;
	// Word moves
	localparam logic [7:0] OP_SW_DIR = 8'hD5;
	localparam logic [7:0] OP_SW_IX = 8'hD6;
	localparam logic [7:0] OP_SW_EXT = 8'hD4;
	localparam logic [7:0] OP_SW_EP = 8'hD7;
	localparam logic [7:0] OP_LW_IMM = 8'hE4;
	localparam logic [7:0] OP_LW_DIR = 8'hC5;
	localparam logic [7:0] OP_LW_IX = 8'hC6;
	localparam logic [7:0] OP_LW_EXT = 8'hC4;
	localparam logic [7:0] OP_LW_ACC = 8'h93;
	localparam logic [7:0] OP_LW_EP = 8'hC7;
	localparam logic [7:0] OP_SW_TMP = 8'h83;
	// Bit operations
	localparam logic [7:0] OP_BSET = 8'hA8;
	localparam logic [7:0] OP_BCLR = 8'hA0;
	// Register-only operations
	localparam logic [7:0] OP_NOP = 8'h00;
	localparam logic [7:0] OP_SWAP = 8'h10;
	localparam logic [7:0] OP_TRADE_LO = 8'h42;
	localparam logic [7:0] OP_TRADE_T = 8'h43;
	localparam logic [7:0] OP_A_PSW = 8'h70;
	localparam logic [7:0] OP_PSW_A = 8'h71;
	localparam logic [7:0] OP_SP_A = 8'hE1;
	localparam logic [7:0] OP_IX_A = 8'hE2;
	localparam logic [7:0] OP_EP_A = 8'hE3;
	localparam logic [7:0] OP_A_PC = 8'hF0;
	localparam logic [7:0] OP_A_SP = 8'hF1;
	localparam logic [7:0] OP_A_IX = 8'hF2;
	localparam logic [7:0] OP_A_EP = 8'hF3;
	localparam logic [7:0] OP_TRADE_SP = 8'hF5;
	localparam logic [7:0] OP_TRADE_IX = 8'hF6;
	localparam logic [7:0] OP_TRADE_EP = 8'hF7;
	localparam logic [7:0] OP_SP_IMM = 8'hE5;
	localparam logic [7:0] OP_IX_IMM = 8'hE6;
	localparam logic [7:0] OP_EP_IMM = 8'hE7;

	typedef enum logic [2:0] {
		ST_FETCH = 3'b000,
		ST_OPND = 3'b001,
		ST_ADDR = 3'b010,
		ST_READ = 3'b011,
		ST_WRITE = 3'b100,
		ST_EXEC = 3'b101
	} tid_state_type;

	typedef enum logic [2:0] {
		AM_NONE = 3'b000,
		AM_DIR = 3'b001,
		AM_IX = 3'b010,
		AM_EXT = 3'b011,
		AM_EP = 3'b100,
		AM_REG = 3'b101,
		AM_ACC = 3'b110
	} tid_amode_type;

	typedef enum logic [3:0] {
		K_NOP = 4'b0000,
		K_LDB = 4'b0001,
		K_LDW = 4'b0010,
		K_STA = 4'b0011,
		K_STW = 4'b0100,
		K_STI = 4'b0101,
		K_STT = 4'b0110,
		K_STTW = 4'b0111,
		K_BSET = 4'b1000,
		K_BCLR = 4'b1001,
		K_REG = 4'b1010,
		K_BAD = 4'b1011
	} tid_kind_type;

	typedef struct packed {
		logic [1:0] len;
		tid_amode_type amode;
		tid_kind_type kind;
		logic [1:0] nrd;
		logic [1:0] nwr;
	} tid_dec_type;

	typedef struct packed {
		logic [15:0] addr;
		logic rd;
		logic wr;
		logic [7:0] wdata;
	} tid_mem_type;

	typedef struct packed {
		logic [15:0] pc;
		logic [15:0] sp;
		logic [15:0] ix;
		logic [15:0] ep;
		logic [15:0] acc;
		logic [15:0] tmp;
		logic [7:0] flag_register;
		logic [4:0] bank;
	} tid_arch_type;

endpackage : tid_pkg

// *** core/tid_addr_gen.sv ***
// Purpose: Effective address former for the transfer instruction decoder
// Assumes: Operand bytes already fetched; index offset is two's complement
// Notes: Purely combinational, the caller registers the result
`timescale 1ns/1ps
`default_nettype none
module tid_addr_gen
	import tid_pkg::*;
(
	input wire tid_amode_type amode_i,
	input wire logic [7:0] opnd1_i,
	input wire logic [7:0] opnd2_i,
	input wire logic [2:0] regno_i,
	input wire logic [4:0] bank_i,
	input wire logic [15:0] ix_i,
	input wire logic [15:0] ep_i,
	input wire logic [15:0] acc_i,
	output logic [15:0] ea_o
);

	logic [15:0] off_ext;

	// Offset is signed so an index can reach below its base
	assign off_ext = {{8{opnd1_i[7]}}, opnd1_i};

	// Mode select; general registers sit in data space by bank and number
	always_comb begin
		case (amode_i)
			AM_DIR: ea_o = {PAGE_ZERO_HI, opnd1_i};
			AM_IX: ea_o = ix_i + off_ext;
			AM_EXT: ea_o = {opnd1_i, opnd2_i};
			AM_EP: ea_o = ep_i;
			AM_REG: ea_o = GREG_BASE + {8'h00, bank_i, regno_i};
			AM_ACC: ea_o = acc_i;
			default: ea_o = 16'h0000;
		endcase
	end

endmodule : tid_addr_gen
`default_nettype wire

// *** verif/tid_mem_model.sv ***
// Purpose: Byte memory seen by the transfer decoder core
// Assumes: One read outstanding; writes land on the strobe cycle
// Notes: Read data toggles while not valid so stale bytes never look right
`timescale 1ns/1ps
`default_nettype none
module tid_mem_model
	import tid_pkg::*;
(
	input wire logic clk_i,
	input wire logic arst_n_i,
	input wire tid_mem_type mem_i,
	input wire logic [1:0] lat_i,
	output logic [7:0] rdata_o,
	output logic rvalid_o
);
	logic [7:0] mem [0:65535];
	logic [15:0] ad;
	logic [1:0] cnt;
	logic pend;

	// Empty memory reads as the no-op code
	initial for (int i = 0; i < 65536; i++) mem[i] = 8'h00;

	// Answer after zero to three extra cycles, as lat_i says
	always @(posedge clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			rvalid_o <= 1'b0;
			pend <= 1'b0;
			cnt <= 2'h0;
			rdata_o <= 8'h5a;
		end else begin
			rvalid_o <= 1'b0;
			rdata_o <= ~rdata_o;
			if (mem_i.wr) mem[mem_i.addr] <= mem_i.wdata;
			if (mem_i.rd) begin
				ad <= mem_i.addr;
				cnt <= lat_i;
				pend <= (lat_i != 2'h0);
				if (lat_i == 2'h0) begin
					rvalid_o <= 1'b1;
					rdata_o <= mem[mem_i.addr];
				end
			end else if (pend) begin
				cnt <= cnt - 2'h1;
				if (cnt == 2'h1) begin
					pend <= 1'b0;
					rvalid_o <= 1'b1;
					rdata_o <= mem[ad];
				end
			end
		end
	end
endmodule : tid_mem_model
`default_nettype wire

// *** verif/tid_core_assertions.sv ***
// Purpose: Port checks for the transfer decoder core
// Assumes: One clock, asynchronous active-low reset
// Notes: Accumulator and flags may only move on the done pulse; pc moves during fetch
`timescale 1ns/1ps
`default_nettype none
module tid_core_assertions
	import tid_pkg::*;
(
	input wire logic clk_i,
	input wire logic arst_n_i,
	input wire tid_mem_type mem_o,
	input wire tid_arch_type arch_o,
	input wire logic instr_done_o,
	input wire logic illegal_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (!arst_n_i);

	// The next opcode fetch at the new pc follows the done pulse by one cycle
	property p_done_fetch;
		instr_done_o |=> mem_o.rd && mem_o.addr == arch_o.pc;
	endproperty
	a_done_fetch: assert property (p_done_fetch) else $error("no fetch at done");
	// Back to back writes are the two halves of a word
	property p_word_pair;
		mem_o.wr ##1 mem_o.wr |-> mem_o.addr == $past(mem_o.addr) + 16'h0001;
	endproperty
	a_word_pair: assert property (p_word_pair) else $error("word halves not adjacent");
	// A read is a single pulse, never two in a row
	property p_rd_pulse;
		mem_o.rd |=> !mem_o.rd && !mem_o.wr;
	endproperty
	a_rd_pulse: assert property (p_rd_pulse) else $error("read strobe too long");
	property p_acc_at_done;
		$changed(arch_o.acc) |-> instr_done_o;
	endproperty
	a_acc_at_done: assert property (p_acc_at_done) else $error("acc moved off done");
	property p_ccr_at_done;
		$changed(arch_o.flag_register) |-> instr_done_o;
	endproperty
	a_ccr_at_done: assert property (p_ccr_at_done) else $error("flags moved off done");
	// Temp only ever receives the accumulator value from before
	property p_tmp_lo;
		$changed(arch_o.tmp[7:0]) |-> arch_o.tmp[7:0] == $past(arch_o.acc[7:0]);
	endproperty
	a_tmp_lo: assert property (p_tmp_lo) else $error("temp low not old acc");
	property p_tmp_hi;
		$changed(arch_o.tmp[15:8]) |-> arch_o.tmp[15:8] == $past(arch_o.acc[15:8]);
	endproperty
	a_tmp_hi: assert property (p_tmp_hi) else $error("temp high not old acc");
	property p_ill_noop;
		instr_done_o && illegal_o |-> $stable(arch_o.acc) && $stable(arch_o.tmp) && $stable(arch_o.flag_register);
	endproperty
	a_ill_noop: assert property (p_ill_noop) else $error("bad code changed state");
	property p_ill_at_done;
		$changed(illegal_o) |-> instr_done_o;
	endproperty
	a_ill_at_done: assert property (p_ill_at_done) else $error("illegal moved off done");

	c_illegal: cover property (instr_done_o && illegal_o);
	c_pair: cover property (mem_o.wr ##1 mem_o.wr);
	c_tmp_hi: cover property (instr_done_o && $changed(arch_o.tmp[15:8]));
endmodule : tid_core_assertions
`default_nettype wire

// *** verif/tb_top.sv ***
// Purpose: Self-checking bench for the transfer decoder core
// Assumes: Memory model answers reads after zero to three extra cycles
// Notes: Each pass reloads a random program under a fresh mid-run reset
`timescale 1ns/1ps
`default_nettype none
module tb_top
	import tid_pkg::*;
;
	logic clk_i = 1'b0;
	logic arst_n_i = 1'b0;
	logic [1:0] lat = 2'h0;
	logic [7:0] rdata;
	logic rvalid;
	tid_mem_type mem;
	tid_arch_type arch;
	logic done;
	logic ill;
	int err_count = 0;
	int check_count = 0;
	int cyc = 0;
	logic [31:0] seed = 32'he921;
	tid_arch_type q_arch[$];
	logic q_ill[$];
	logic [23:0] q_wr[$];

	always #2 clk_i = ~clk_i;

	tid_core dut (.clk_i(clk_i), .arst_n_i(arst_n_i), .mem_rdata_i(rdata), .mem_rvalid_i(rvalid),
		.mem_o(mem), .arch_o(arch), .instr_done_o(done), .illegal_o(ill));
	tid_mem_model u_mem (.clk_i(clk_i), .arst_n_i(arst_n_i), .mem_i(mem), .lat_i(lat),
		.rdata_o(rdata), .rvalid_o(rvalid));

	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : lfsr

	function automatic logic [7:0] nz(input logic n, input logic z);
		return {4'h0, n, z, 2'b00};
	endfunction : nz

	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", check_count, err_count);
		if (err_count == 0 && check_count > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : tally_and_finish

	task automatic cmp_arch(input tid_arch_type e, input tid_arch_type g);
		check_count++;
		if (g !== e) begin
			err_count++;
			$display("[ERR] arch exp %h got %h", e, g);
		end
	endtask : cmp_arch

	task automatic cmp_bit(input logic e, input logic g);
		check_count++;
		if (g !== e) begin
			err_count++;
			$display("[ERR] illegal exp %b got %b", e, g);
		end
	endtask : cmp_bit

	task automatic cmp_wr(input logic [23:0] e, input logic [23:0] g);
		check_count++;
		if (g !== e) begin
			err_count++;
			$display("[ERR] write exp %h got %h", e, g);
		end
	endtask : cmp_wr

	// Notes for the watcher: state after a done, and each byte write
	task automatic ex(input logic [15:0] pc, input logic [15:0] acc, input logic [15:0] tmp,
		input logic [7:0] cc, input logic il);
		tid_arch_type e;
		e = '0;
		e.pc = pc;
		e.acc = acc;
		e.tmp = tmp;
		e.flag_register = cc;
		q_arch.push_back(e);
		q_ill.push_back(il);
	endtask : ex

	task automatic wx(input logic [15:0] ad, input logic [7:0] d);
		q_wr.push_back({ad, d});
	endtask : wx

	// Watch settled outputs half a cycle after each edge
	always @(negedge clk_i) begin
		if (arst_n_i === 1'b1 && done === 1'b1) begin
			if (q_arch.size() == 0) begin
				err_count++;
				$display("[ERR] done exp 0 got 1");
			end else begin
				cmp_arch(q_arch.pop_front(), arch);
				cmp_bit(q_ill.pop_front(), ill);
			end
		end
		if (arst_n_i === 1'b1 && mem.wr === 1'b1) begin
			if (q_wr.size() == 0) begin
				err_count++;
				$display("[ERR] write exp 0 got 1");
			end else begin
				cmp_wr(q_wr.pop_front(), {mem.addr, mem.wdata});
			end
		end
	end

	// Random read latency each cycle; the ceiling cuts a hang short
	always @(posedge clk_i) begin
		#1;
		seed = lfsr(seed);
		lat = seed[1:0];
		cyc++;
		if (cyc == 20000) begin
			err_count++;
			tally_and_finish();
		end
	end

	// One pass: reset, load program, note results, wait for them
	task automatic run_iter();
		logic [15:0] w;
		logic [15:0] a;
		logic [7:0] b;
		logic [7:0] c2;
		logic [7:0] c4;
		logic [2:0] ri;
		logic [2:0] bt;
		logic [7:0] p [0:23];
		int i;
		@(posedge clk_i);
		#1 arst_n_i = 1'b0;
		q_arch.delete();
		q_ill.delete();
		q_wr.delete();
		@(negedge clk_i);
		// Pointer kept high so the pointer store misses program and data
		w = {1'b1, seed[14:0]};
		b = seed[23:16];
		ri = seed[26:24];
		bt = seed[29:27];
		a = {w[15:8], b};
		c2 = nz(b[7], b == 8'h00);
		c4 = nz(1'b1, 1'b0);
		p = '{OP_LW_IMM, w[15:8], w[7:0], OP_LD_IMM, b, OP_SW_DIR, 8'h40, OP_LW_DIR, 8'h40,
			OP_SW_TMP, OP_ST_REG | ri, OP_LD_REG | ri, 8'h01, OP_BSET | bt, 8'h41,
			OP_SWAP, OP_BCLR | bt, 8'h41, OP_SI_DIR, 8'h42, b, OP_LD_EXT, 8'h00, 8'h42};
		for (i = 0; i < 24; i++) u_mem.mem[i] = p[i];
		ex(16'h0003, w, 16'h0000, nz(w[15], w == 16'h0000), 1'b0);
		ex(16'h0005, a, {8'h00, w[7:0]}, c2, 1'b0);
		wx(16'h0040, w[15:8]);
		wx(16'h0041, b);
		ex(16'h0007, a, {8'h00, w[7:0]}, c2, 1'b0);
		ex(16'h0009, a, a, c4, 1'b0);
		wx(a, a[15:8]);
		wx(a + 16'h0001, b);
		ex(16'h000a, a, a, c4, 1'b0);
		wx(16'h0100 + {13'h0000, ri}, b);
		ex(16'h000b, a, a, c4, 1'b0);
		ex(16'h000c, a, a, c2, 1'b0);
		ex(16'h000d, a, a, c2, 1'b1);
		wx(16'h0041, b | (8'h01 << bt));
		ex(16'h000f, a, a, c2, 1'b0);
		ex(16'h0010, {b, w[15:8]}, a, c2, 1'b0);
		wx(16'h0041, b & ~(8'h01 << bt));
		ex(16'h0012, {b, w[15:8]}, a, c2, 1'b0);
		wx(16'h0042, b);
		ex(16'h0015, {b, w[15:8]}, a, c2, 1'b0);
		ex(16'h0018, {b, b}, {w[15:8], w[15:8]}, c2, 1'b0);
		repeat (8) @(posedge clk_i);
		#1 arst_n_i = 1'b1;
		i = 0;
		while ((q_arch.size() + q_wr.size()) > 0 && i < 3000) begin
			@(negedge clk_i);
			i++;
		end
		if (i == 3000)
			err_count++;
	endtask : run_iter

	// Main sequence
	initial begin
		repeat (6) run_iter();
		tally_and_finish();
	end
endmodule : tb_top

bind tid_core tid_core_assertions u_chk (.clk_i(clk_i), .arst_n_i(arst_n_i), .mem_o(mem_o),
	.arch_o(arch_o), .instr_done_o(instr_done_o), .illegal_o(illegal_o));
`default_nettype wire
